// ===== rtl/etp_map.svh
// register offsets, field positions and option reset value of the eight-bit timer
`ifndef ETP_MAP_SVH
`define ETP_MAP_SVH
`define ETP_OFS_OPTION 4'h0
`define ETP_OFS_COUNT 4'h4
`define ETP_OFS_INTCTRL 4'h8
`define ETP_OFS_GATE 4'hc
`define ETP_BIT_BYPASS 3
`define ETP_BIT_EXTMODE 5
`define ETP_BIT_EXTEDGE 4
`define ETP_BIT_FLAG 2
`define ETP_BIT_IE 5
`define ETP_OPTION_RST 8'hff
`define ETP_PHASES 2'h3
`define ETP_RATIO_W 3
`endif

// ===== rtl/etp_pkg.sv
// types shared by the eight-bit timer files
package etp_pkg;
    typedef struct packed {
        logic bypass;
        logic [2:0] ratio;
        logic ext_mode;
        logic ext_falling;
    } etp_cfg_s;
    typedef enum logic [3:0] {
        ETP_FIRST_QUARTER = 4'h1,
        ETP_SECOND_QUARTER = 4'h2,
        ETP_THIRD_QUARTER = 4'h4,
        ETP_FOURTH_QUARTER = 4'h8
    } etp_phase_e;
endpackage : etp_pkg

// ===== rtl/etp_prescaler.sv
// dedicated power-of-two prescaler with bypass and clear
`timescale 1ns/1ps
`default_nettype none
`include "etp_map.svh"
module etp_prescaler (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic clear_in,
    input wire etp_pkg::etp_cfg_s cfg_in,
    output logic tick_out
);
    logic [7:0] presc_reg;
    logic [7:0] presc_next;
    logic [7:0] mask;
    always_comb begin
        mask = 8'hff >> (3'h7 - cfg_in.ratio);
        presc_next = presc_reg;
        tick_out = 1'b0;
        if (clear_in) begin
            presc_next = 8'h00;
        end else if (tick_in) begin
            if (cfg_in.bypass) begin
                tick_out = 1'b1;
            end else begin
                presc_next = (presc_reg + 8'h01) & mask;
                tick_out = ((presc_reg & mask) == mask);
            end
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc_reg <= 8'h00;
        end else begin
            presc_reg <= presc_next;
        end
    end
    a_div_bypass: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_in && !clear_in && cfg_in.bypass) |-> tick_out)
        else $error("bypass did not pass tick");
    a_clear_presc: assert property (@(posedge clk_in) disable iff (rst_in)
        clear_in |=> presc_reg == 8'h00)
        else $error("prescaler not cleared by count write");
    a_idle_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        (!tick_in || clear_in) |-> !tick_out)
        else $error("prescaler ticked without input");
endmodule : etp_prescaler
`default_nettype wire

// ===== rtl/etp_timer.sv
// eight-bit timer with prescaler, overflow flag and gate pulse
`timescale 1ns/1ps
`default_nettype none
`include "etp_map.svh"
module etp_timer (
    input wire logic REF_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic EXT_COUNT_CLOCK_IN,
    input wire logic SLEEP_IN,
    input wire logic [1:0] SLOW_GATE_SOURCE_SELECT_IN,
    output logic OVERFLOW_IRQ_OUT,
    output logic OVERFLOW_PULSE_OUT,
    output logic SLOW_GATE_OVF_OUT
);
    // ****************************************
    // phase generator and pin synchroniser
    // ****************************************
    etp_pkg::etp_phase_e phase_reg;
    etp_pkg::etp_phase_e phase_next;
    logic [1:0] ext_sync_reg;
    logic ext_sample_reg;
    logic ext_sample_next;
    logic ext_prev_reg;
    logic ext_prev_next;
    logic sample_phase;
    assign sample_phase = phase_reg == etp_pkg::ETP_SECOND_QUARTER
        || phase_reg == etp_pkg::ETP_FOURTH_QUARTER;
    always_comb begin
        case (phase_reg)
            etp_pkg::ETP_FIRST_QUARTER: phase_next = etp_pkg::ETP_SECOND_QUARTER;
            etp_pkg::ETP_SECOND_QUARTER: phase_next = etp_pkg::ETP_THIRD_QUARTER;
            etp_pkg::ETP_THIRD_QUARTER: phase_next = etp_pkg::ETP_FOURTH_QUARTER;
            etp_pkg::ETP_FOURTH_QUARTER: phase_next = etp_pkg::ETP_FIRST_QUARTER;
            default: phase_next = etp_pkg::ETP_FIRST_QUARTER;
        endcase
    end
    // second stage read only by the phase sampler
    always_comb begin
        ext_sample_next = ext_sample_reg;
        ext_prev_next = ext_prev_reg;
        if (sample_phase) begin
            ext_sample_next = ext_sync_reg[1];
            ext_prev_next = ext_sample_reg;
        end
    end
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            phase_reg <= etp_pkg::ETP_FIRST_QUARTER;
            ext_sync_reg <= 2'h0;
            ext_sample_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            ext_sync_reg <= {ext_sync_reg[0], EXT_COUNT_CLOCK_IN};
            ext_sample_reg <= ext_sample_next;
            ext_prev_reg <= ext_prev_next;
        end
    end
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] option_reg;
    logic [7:0] option_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic flag_reg;
    logic flag_next;
    logic ie_reg;
    logic ie_next;
    logic pulse_reg;
    logic pulse_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    etp_pkg::etp_cfg_s cfg;
    logic instr_tick;
    logic ext_edge;
    logic pre_in;
    logic pre_out;
    logic wr_count;
    logic wr_lo;
    logic wrap;
    logic wr_option;
    logic wr_intctrl;
    logic rd_take;
    logic rd_valid_reg;
    logic rd_valid_next;
    assign cfg.bypass = option_reg[`ETP_BIT_BYPASS];
    assign cfg.ratio = option_reg[`ETP_RATIO_W-1:0];
    assign cfg.ext_mode = option_reg[`ETP_BIT_EXTMODE];
    assign cfg.ext_falling = option_reg[`ETP_BIT_EXTEDGE];
    // one instruction cycle every four reference clocks
    assign instr_tick = (phase_reg == etp_pkg::ETP_FOURTH_QUARTER);
    assign ext_edge = sample_phase
        && (cfg.ext_falling ? (ext_prev_reg && !ext_sample_reg)
                            : (!ext_prev_reg && ext_sample_reg));
    // sleep gates the prescaler input so prescaler and count stop advancing
    assign pre_in = !SLEEP_IN && (cfg.ext_mode ? ext_edge : instr_tick);
    assign wr_lo = AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
    assign wr_count = wr_lo && AVS_ADDRESS_IN == `ETP_OFS_COUNT;
    assign wr_option = wr_lo && AVS_ADDRESS_IN == `ETP_OFS_OPTION;
    assign wr_intctrl = wr_lo && AVS_ADDRESS_IN == `ETP_OFS_INTCTRL;
    assign rd_take = AVS_READ_IN && !rd_valid_reg;
    etp_prescaler u_presc (
        .clk_in(REF_CLK_IN),
        .rst_in(SYS_RST_IN),
        .tick_in(pre_in),
        .clear_in(wr_count),
        .cfg_in(cfg),
        .tick_out(pre_out)
    );
    assign wrap = pre_out && !wr_count && count_reg == 8'hff;
    // ****************************************
    // configuration group
    // ****************************************
    always_comb begin
        option_next = option_reg;
        ie_next = ie_reg;
        if (wr_option) begin
            option_next = AVS_WRITEDATA_IN[7:0];
        end
        if (wr_intctrl) begin
            ie_next = AVS_WRITEDATA_IN[`ETP_BIT_IE];
        end
    end
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            option_reg <= `ETP_OPTION_RST;
            ie_reg <= 1'b0;
        end else begin
            option_reg <= option_next;
            ie_reg <= ie_next;
        end
    end
    // ****************************************
    // count group
    // ****************************************
    // a write in the same cycle as a tick wins; that tick is lost
    always_comb begin
        count_next = count_reg;
        pulse_next = wrap;
        if (wr_count) begin
            count_next = AVS_WRITEDATA_IN[7:0];
        end else if (pre_out) begin
            count_next = count_reg + 8'h01;
        end
    end
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            count_reg <= 8'h00;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            pulse_reg <= pulse_next;
        end
    end
    // ****************************************
    // flag group
    // ****************************************
    always_comb begin
        flag_next = flag_reg;
        if (wr_intctrl) begin
            flag_next = AVS_WRITEDATA_IN[`ETP_BIT_FLAG];
        end
        // set beats a simultaneous software clear
        if (wrap) begin
            flag_next = 1'b1;
        end
    end
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    // ****************************************
    // bus response group
    // ****************************************
    // one wait state per read buys read data straight from a flop
    always_comb begin
        rd_valid_next = rd_take;
        rdata_next = rdata_reg;
        if (rd_take) begin
            rdata_next = 32'h0;
            case (AVS_ADDRESS_IN)
                `ETP_OFS_OPTION: rdata_next = {24'h0, option_reg};
                `ETP_OFS_COUNT: rdata_next = {24'h0, count_reg};
                `ETP_OFS_INTCTRL: rdata_next = {26'h0, ie_reg, 2'h0, flag_reg, 2'h0};
                `ETP_OFS_GATE: rdata_next = {30'h0, SLOW_GATE_SOURCE_SELECT_IN};
                default: rdata_next = 32'h0;
            endcase
        end
    end
    always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rd_valid_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rdata_reg <= rdata_next;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    // reads wait one cycle, writes none
    assign AVS_WAITREQUEST_OUT = rd_take;
    assign AVS_READDATA_OUT = rdata_reg;
    // level request only; no wake path out of sleep exists
    assign OVERFLOW_IRQ_OUT = flag_reg && ie_reg && !SLEEP_IN;
    assign OVERFLOW_PULSE_OUT = pulse_reg;
    assign SLOW_GATE_OVF_OUT = pulse_reg && SLOW_GATE_SOURCE_SELECT_IN == 2'h1;
    // ****************************************
    // checks
    // ****************************************
    a_flag_sticky: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (flag_reg && !(wr_lo && AVS_ADDRESS_IN == `ETP_OFS_INTCTRL)) |=> flag_reg)
        else $error("overflow flag cleared by hardware");
    a_flag_on_wrap: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        wrap |=> flag_reg && count_reg == 8'h00)
        else $error("wrap did not set flag");
    a_pulse_wrap: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        OVERFLOW_PULSE_OUT |-> $past(count_reg) == 8'hff && count_reg == 8'h00)
        else $error("pulse without wrap");
    a_sleep_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (SLEEP_IN && !wr_count) |=> $stable(count_reg))
        else $error("count moved during sleep");
    a_irq_gate: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        OVERFLOW_IRQ_OUT |-> ie_reg && flag_reg)
        else $error("irq without enable");
    a_gate_route: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        SLOW_GATE_OVF_OUT |-> SLOW_GATE_SOURCE_SELECT_IN == 2'h1 && pulse_reg)
        else $error("gate routed wrongly");
    a_write_count: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        wr_count |=> count_reg == $past(AVS_WRITEDATA_IN[7:0]))
        else $error("count write lost");
    a_timer_rate: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (cfg.bypass && !cfg.ext_mode && !SLEEP_IN && !wr_count && instr_tick)
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("timer did not advance");
    a_irq_raise: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (wrap && ie_reg && !wr_intctrl) |=> (OVERFLOW_IRQ_OUT || SLEEP_IN))
        else $error("wrap with enable gave no irq");
    a_irq_sleep: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        SLEEP_IN |-> !OVERFLOW_IRQ_OUT)
        else $error("irq raised during sleep");
    a_ie_write: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        wr_intctrl |=> ie_reg == $past(AVS_WRITEDATA_IN[`ETP_BIT_IE]))
        else $error("enable write lost");
    a_flag_write: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (wr_intctrl && !wrap) |=> flag_reg == $past(AVS_WRITEDATA_IN[`ETP_BIT_FLAG]))
        else $error("flag write lost");
    a_pulse_single: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        OVERFLOW_PULSE_OUT |=> !OVERFLOW_PULSE_OUT)
        else $error("overflow pulse longer than one cycle");
    a_gate_follow: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (OVERFLOW_PULSE_OUT && SLOW_GATE_SOURCE_SELECT_IN == 2'h1) |-> SLOW_GATE_OVF_OUT)
        else $error("gate missed overflow");
    a_ext_sample: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !$stable(ext_sample_reg) |-> $past(phase_reg) == etp_pkg::ETP_SECOND_QUARTER
            || $past(phase_reg) == etp_pkg::ETP_FOURTH_QUARTER)
        else $error("pin sampled off phase");
    a_ext_quiet: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (cfg.ext_mode && !ext_edge && !wr_count) |=> $stable(count_reg))
        else $error("count moved without pin edge");
    a_count_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (!pre_out && !wr_count) |=> $stable(count_reg))
        else $error("count moved without tick");
    a_option_write: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        wr_option |=> option_reg == $past(AVS_WRITEDATA_IN[7:0]))
        else $error("option write lost");
    // ****************************************
    // bus checks
    // ****************************************
    a_read_one_wait: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (AVS_READ_IN && AVS_WAITREQUEST_OUT) |=> !AVS_WAITREQUEST_OUT)
        else $error("read waited more than one cycle");
    a_write_nowait: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (AVS_WRITE_IN && !AVS_READ_IN) |-> !AVS_WAITREQUEST_OUT)
        else $error("write was stalled");
    a_rdata_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        !rd_take |=> $stable(AVS_READDATA_OUT))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
        (rd_take && AVS_ADDRESS_IN == 4'h1) |=> AVS_READDATA_OUT == 32'h0)
        else $error("unmapped address read nonzero");
endmodule : etp_timer
`default_nettype wire

// ===== verification/etp_ext_src.sv
// external count source that drives pulse bursts onto the count pin
`timescale 1ns/1ps
`default_nettype none
// ************
// burst source
// ************
module etp_ext_src (
    input wire logic clk_in,
    input wire logic go_in,
    output logic pin_out
);
    // 12-clock phases outlast the two-flop sync plus quarter-phase sampling
    initial pin_out = 1'b0;
    always begin
        @(posedge go_in);
        repeat (5) begin
            repeat (12) @(posedge clk_in);
            pin_out <= 1'b1;
            repeat (12) @(posedge clk_in);
            pin_out <= 1'b0;
        end
    end
endmodule : etp_ext_src
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the eight-bit timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("[ERR] t=%0t got %h exp %h", $time, a, b); \
    end \
end
// *********
// top level
// *********
module tb_top;
    logic clk, rst, rd, wr, sleep, go, wreq, irq, pls, gate, ext, pls_q;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, v, w;
    logic [1:0] sel;
    int errors, samples_checked, cyc, npls, d, t0, n0;
    etp_timer dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hf),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .EXT_COUNT_CLOCK_IN(ext),
        .SLEEP_IN(sleep), .SLOW_GATE_SOURCE_SELECT_IN(sel), .OVERFLOW_IRQ_OUT(irq),
        .OVERFLOW_PULSE_OUT(pls), .SLOW_GATE_OVF_OUT(gate));
    etp_ext_src src (.clk_in(clk), .go_in(go), .pin_out(ext));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // gate watch runs every cycle so a stray pulse is never missed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst) begin
            `CHK(gate, pls && sel == 2'b01)
            `CHK(pls && pls_q, 1'b0)
            if (pls) npls <= npls + 1;
        end
        pls_q <= pls;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // request held until the rising edge that sees waitrequest low
    task rdr(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        rd <= 1'b0;
    endtask : rdr
    task wrr(input logic [3:0] a, input logic [7:0] dv);
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, dv};
        wr <= 1'b1;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    // polling costs three clocks a read, so intervals carry two clocks of slack
    task meas(output int dd);
        logic [31:0] a0, a1;
        int t;
        rdr(4'h4, a0);
        do rdr(4'h4, a1); while (a1 === a0);
        t = cyc;
        do rdr(4'h4, a0); while (a0 === a1);
        dd = cyc - t;
    endtask : meas
    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0;
        sleep = 1'b0; sel = 2'b01; go = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdr(4'h0, v); `CHK(v, 32'hff)
        rdr(4'h4, v); `CHK(v, 32'h0)
        rdr(4'h8, v); `CHK(v, 32'h0)
        rdr(4'h1, v); `CHK(v, 32'h0)
        rdr(4'hc, v); `CHK(v, 32'h1)
        $display("test reset done");
        wrr(4'h0, 8'h08);
        meas(d); `CHK(d >= 2 && d <= 6, 1'b1)
        n0 = npls;
        wrr(4'h4, 8'hff);
        wait (npls > n0);
        rdr(4'h8, v); `CHK(v[7:0], 8'h04)
        @(negedge clk); `CHK(irq, 1'b0)
        wrr(4'h8, 8'h24);
        @(negedge clk); `CHK(irq, 1'b1)
        @(posedge clk) sleep <= 1'b1;
        rdr(4'h4, v);
        repeat (40) @(posedge clk);
        rdr(4'h4, w); `CHK(w, v)
        @(negedge clk); `CHK(irq, 1'b0)
        rdr(4'h8, v); `CHK(v[2], 1'b1)
        @(posedge clk) sleep <= 1'b0;
        wrr(4'h8, 8'h20);
        @(negedge clk); `CHK(irq, 1'b0)
        @(posedge clk) sel <= 2'b10;
        $display("test overflow done");
        for (int n = 0; n < 8; n++) begin
            wrr(4'h0, 8'(n));
            meas(d); `CHK(d >= (8 << n) - 2 && d <= (8 << n) + 2, 1'b1)
        end
        $display("test ratio done");
        wrr(4'h4, 8'h10);
        repeat (600) @(posedge clk);
        wrr(4'h4, 8'h20);
        t0 = cyc;
        do rdr(4'h4, v); while (v === 32'h20);
        `CHK(cyc - t0 >= 1020 && cyc - t0 <= 1032, 1'b1)
        $display("test clear done");
        for (int m = 0; m < 2; m++) begin
            wrr(4'h0, m ? 8'h38 : 8'h28);
            wrr(4'h4, 8'h00);
            @(posedge clk) go <= 1'b1;
            repeat (140) @(posedge clk);
            go <= 1'b0;
            rdr(4'h4, v); `CHK(v, 32'h5)
        end
        $display("test external done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
